// file: stt_cmd.sv
`timescale 1ns/10ps
module stt_cmd #(
   parameter int FIFO_DEPTH = stt_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   input wire logic ttl_in,
   input wire logic online_key,
   input wire logic local_req,
   input wire logic [15:0] repeat_count,
   output logic free_run_continuous,
   output logic motor_power_en,
   output logic online,
   output stt_pkg::stt_time_t delay_time,
   output logic delay_load,
   output stt_pkg::stt_time_t expo_time,
   output logic expo_load,
   output stt_pkg::stt_trig_mode_t trig_mode,
   output logic shutter_open,
   output logic cmd_rejected
);

   typedef enum logic [2:0] {
      S_IDLE,
      S_SEL_HOURS,
      S_MINUTES,
      S_SECONDS,
      S_MS_HIGH,
      S_MS_LOW,
      S_REPLY
   } stt_state_t;

   stt_state_t state_ff;
   logic f_valid, f_ready, take, is_delay_ff, time_good;
   logic [7:0] f_data, tx_data_ff;
   logic [1:0] reply_idx_ff;
   stt_pkg::stt_time_t shadow_ff, full_time, delay_ff, expo_ff;
   logic motor_en_ff, online_ff, delay_load_ff, expo_load_ff, reject_ff;
   stt_pkg::stt_trig_mode_t mode_ff;
   logic ttl_s1_ff, ttl_s2_ff, ttl_prev_ff, shutter_ff, ttl_rise, ttl_fall;

   // command bytes are buffered so the host may burst ahead of the decoder
   stt_fifo #(
      .WIDTH(stt_pkg::BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data(rx_data),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // decoder stalls while the reply drains, which backs up the fifo
   assign f_ready = (state_ff != S_REPLY);
   assign take = f_valid && f_ready;

   // range check of a whole time word
   function automatic logic time_in_range(input stt_pkg::stt_time_t t);
      logic ok;
      ok = (t.hours <= stt_pkg::HOURS_MAX);
      ok = ok && (t.minutes <= stt_pkg::MINUTES_MAX) && (t.seconds <= stt_pkg::SECONDS_MAX);
      ok = ok && (t.ms_hundreds <= stt_pkg::BCD_MAX) && (t.ms_tens <= stt_pkg::BCD_MAX);
      ok = ok && (t.ms_ones <= stt_pkg::BCD_MAX) && (t.ms_tenths <= stt_pkg::BCD_MAX);
      // five hours is the ceiling, so anything beyond it is refused as well
      if (t.hours == stt_pkg::HOURS_MAX)
         ok = ok && (t.minutes == 8'h00) && (t.seconds == 8'h00) &&
              ({t.ms_hundreds, t.ms_tens, t.ms_ones, t.ms_tenths} == 16'h0000);
      return ok;
   endfunction

   // last byte completes the word; checked before anything is loaded
   always_comb
   begin
      full_time = shadow_ff;
      full_time.ms_ones = f_data[7:4];
      full_time.ms_tenths = f_data[3:0];
      time_good = time_in_range(full_time);
   end

   // command parser
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= S_IDLE;
         is_delay_ff <= 1'b0;
         shadow_ff <= '0;
         reply_idx_ff <= '0;
      end
      else
      begin
         case (state_ff)
            S_IDLE:
               if (take && online_ff)
               begin
                  if (f_data == stt_pkg::SPECIAL_PREFIX)
                     state_ff <= S_SEL_HOURS;
                  else if (f_data == stt_pkg::CMD_STATUS_TAIL)
                  begin
                     state_ff <= S_REPLY;
                     reply_idx_ff <= '0;
                  end
               end
            S_SEL_HOURS:
               if (take)
               begin
                  // an unknown selector aborts the frame at once
                  if ((f_data[7:4] == stt_pkg::SEL_DELAY) || (f_data[7:4] == stt_pkg::SEL_EXPOSURE))
                  begin
                     is_delay_ff <= (f_data[7:4] == stt_pkg::SEL_DELAY);
                     shadow_ff.hours <= f_data[3:0];
                     state_ff <= S_MINUTES;
                  end
                  else
                     state_ff <= S_IDLE;
               end
            S_MINUTES:
               if (take)
               begin
                  shadow_ff.minutes <= f_data;
                  state_ff <= S_SECONDS;
               end
            S_SECONDS:
               if (take)
               begin
                  shadow_ff.seconds <= f_data;
                  state_ff <= S_MS_HIGH;
               end
            S_MS_HIGH:
               if (take)
               begin
                  shadow_ff.ms_hundreds <= f_data[7:4];
                  shadow_ff.ms_tens <= f_data[3:0];
                  state_ff <= S_MS_LOW;
               end
            S_MS_LOW:
               if (take)
                  state_ff <= S_IDLE;
            S_REPLY:
               if (tx_ready)
               begin
                  if (reply_idx_ff == stt_pkg::REPLY_LAST_IDX)
                     state_ff <= S_IDLE;
                  else
                     reply_idx_ff <= reply_idx_ff + 2'h1;
               end
            default:
               state_ff <= S_IDLE;
         endcase
      end
   end

   // timer words only change on a fully valid frame
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         delay_ff <= '0;
         expo_ff <= '0;
         delay_load_ff <= 1'b0;
         expo_load_ff <= 1'b0;
         reject_ff <= 1'b0;
      end
      else
      begin
         delay_load_ff <= 1'b0;
         expo_load_ff <= 1'b0;
         reject_ff <= 1'b0;
         if ((state_ff == S_SEL_HOURS) && take &&
             (f_data[7:4] != stt_pkg::SEL_DELAY) && (f_data[7:4] != stt_pkg::SEL_EXPOSURE))
            reject_ff <= 1'b1;
         if ((state_ff == S_MS_LOW) && take)
         begin
            if (!time_good)
               reject_ff <= 1'b1;
            else if (is_delay_ff)
            begin
               delay_ff <= full_time;
               delay_load_ff <= 1'b1;
            end
            else
            begin
               expo_ff <= full_time;
               expo_load_ff <= 1'b1;
            end
         end
      end
   end

   // reply byte register; count goes upper byte first, then lower byte, then the terminator
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         tx_data_ff <= 8'h00;
      else if ((state_ff == S_IDLE) && take && online_ff && (f_data == stt_pkg::CMD_STATUS_TAIL))
         tx_data_ff <= repeat_count[15:8];
      else if ((state_ff == S_REPLY) && tx_ready)
      begin
         if (reply_idx_ff == 2'h0)
            tx_data_ff <= repeat_count[7:0];
         else
            tx_data_ff <= stt_pkg::REPLY_TERMINATOR;
      end
   end

   assign tx_valid = (state_ff == S_REPLY);
   assign tx_data = tx_data_ff;

   // above the limit the free run repeats without end
   assign free_run_continuous = (repeat_count > stt_pkg::REPEAT_LIMIT);

   // motor power and on-line state; local mode ignores all but go-online
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         motor_en_ff <= stt_pkg::RST_MOTOR_EN;
         online_ff <= stt_pkg::RST_ONLINE;
      end
      else
      begin
         if ((state_ff == S_IDLE) && take && online_ff)
         begin
            if (f_data == stt_pkg::CMD_MOTOR_ON)
               motor_en_ff <= 1'b1;
            else if (f_data == stt_pkg::CMD_MOTOR_OFF)
               motor_en_ff <= 1'b0;
         end
         // going on line wins over a same-cycle local request
         if (online_key || ((state_ff == S_IDLE) && take && (f_data == stt_pkg::CMD_GO_ONLINE)))
            online_ff <= 1'b1;
         else if (local_req)
            online_ff <= 1'b0;
      end
   end

   // trigger mode: the last command received replaces any earlier one
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_ff <= stt_pkg::TRIG_DISABLED;
      else if ((state_ff == S_IDLE) && take && online_ff)
      begin
         case (f_data)
            stt_pkg::CMD_TRIG_DISABLE: mode_ff <= stt_pkg::TRIG_DISABLED;
            stt_pkg::CMD_TRIG_HIGH: mode_ff <= stt_pkg::TRIG_LEVEL_HIGH;
            stt_pkg::CMD_TRIG_LOW: mode_ff <= stt_pkg::TRIG_LEVEL_LOW;
            stt_pkg::CMD_TRIG_RISE: mode_ff <= stt_pkg::TRIG_RISE_TOGGLE;
            stt_pkg::CMD_TRIG_FALL: mode_ff <= stt_pkg::TRIG_FALL_TOGGLE;
            default: mode_ff <= mode_ff;
         endcase
      end
   end

   // trigger pin synchroniser; edges are taken from the second stage only
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ttl_s1_ff <= 1'b0;
         ttl_s2_ff <= 1'b0;
         ttl_prev_ff <= 1'b0;
      end
      else
      begin
         ttl_s1_ff <= ttl_in;
         ttl_s2_ff <= ttl_s1_ff;
         ttl_prev_ff <= ttl_s2_ff;
      end
   end

   assign ttl_rise = ttl_s2_ff && !ttl_prev_ff;
   assign ttl_fall = !ttl_s2_ff && ttl_prev_ff;

   // shutter state; a pin held high through reset reads as one rising edge
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         shutter_ff <= stt_pkg::RST_SHUTTER_OPEN;
      else
      begin
         case (mode_ff)
            stt_pkg::TRIG_DISABLED: shutter_ff <= shutter_ff;
            stt_pkg::TRIG_LEVEL_HIGH: shutter_ff <= ttl_s2_ff;
            stt_pkg::TRIG_LEVEL_LOW: shutter_ff <= !ttl_s2_ff;
            stt_pkg::TRIG_RISE_TOGGLE: shutter_ff <= ttl_rise ? !shutter_ff : shutter_ff;
            stt_pkg::TRIG_FALL_TOGGLE: shutter_ff <= ttl_fall ? !shutter_ff : shutter_ff;
            default: shutter_ff <= shutter_ff;
         endcase
      end
   end

   // outputs straight from their registers
   assign motor_power_en = motor_en_ff;
   assign online = online_ff;
   assign delay_time = delay_ff;
   assign delay_load = delay_load_ff;
   assign expo_time = expo_ff;
   assign expo_load = expo_load_ff;
   assign trig_mode = mode_ff;
   assign shutter_open = shutter_ff;
   assign cmd_rejected = reject_ff;

endmodule

// file: stt_cmd_assertions.sv
`timescale 1ns/10ps
module stt_cmd_assertions (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic ttl_in,
   input wire logic [15:0] repeat_count,
   input wire logic free_run_continuous,
   input wire stt_pkg::stt_time_t delay_time,
   input wire logic delay_load,
   input wire stt_pkg::stt_time_t expo_time,
   input wire logic expo_load,
   input wire stt_pkg::stt_trig_mode_t trig_mode,
   input wire logic shutter_open
);
   logic [1:0] acc_ff;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // accepted reply bytes; cleared whenever no reply is on offer
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         acc_ff <= 2'h0;
      else if (!tx_valid)
         acc_ff <= 2'h0;
      else if (tx_ready)
         acc_ff <= acc_ff + 2'h1;

   // a loaded time must lie inside the shared format
   function automatic logic ok_t(stt_pkg::stt_time_t t);
      return t.hours <= 4'h5 && t.minutes <= 8'h3B && t.seconds <= 8'h3B && t.ms_hundreds <= 4'h9
         && t.ms_tens <= 4'h9 && t.ms_ones <= 4'h9 && t.ms_tenths <= 4'h9 && (t.hours != 4'h5 || t[31:0] == 32'h0);
   endfunction

   property p_hi_first;
      $rose(tx_valid) |-> tx_data == $past(repeat_count[15:8]);
   endproperty
   a_hi_first: assert property (p_hi_first) else $error("reply upper byte wrong");
   property p_lo_second;
      tx_valid && acc_ff == 2'h1 && $changed(acc_ff) |-> tx_data == $past(repeat_count[7:0]);
   endproperty
   a_lo_second: assert property (p_lo_second) else $error("reply lower byte wrong");
   property p_continuous;
      free_run_continuous == (repeat_count > 16'hFDE8);
   endproperty
   a_continuous: assert property (p_continuous) else $error("continuous flag wrong");
   property p_term;
      tx_valid && acc_ff == 2'h2 |-> tx_data == 8'h0D;
   endproperty
   a_term: assert property (p_term) else $error("reply not ended by carriage return");
   property p_delay_hold;
      !delay_load |-> $stable(delay_time);
   endproperty
   a_delay_hold: assert property (p_delay_hold) else $error("delay time moved without load");
   property p_expo_hold;
      !expo_load |-> $stable(expo_time);
   endproperty
   a_expo_hold: assert property (p_expo_hold) else $error("exposure time moved without load");
   property p_range;
      delay_load || expo_load |-> ok_t(delay_time) && ok_t(expo_time);
   endproperty
   a_range: assert property (p_range) else $error("out of range time loaded");
   property p_disabled;
      trig_mode == stt_pkg::TRIG_DISABLED && $past(trig_mode) == stt_pkg::TRIG_DISABLED |-> $stable(shutter_open);
   endproperty
   a_disabled: assert property (p_disabled) else $error("shutter moved while trigger disabled");
   property p_high;
      (trig_mode == stt_pkg::TRIG_LEVEL_HIGH) [*4] |-> shutter_open == $past(ttl_in, 3);
   endproperty
   a_high: assert property (p_high) else $error("shutter not following high level");
   property p_low;
      (trig_mode == stt_pkg::TRIG_LEVEL_LOW) [*4] |-> shutter_open != $past(ttl_in, 3);
   endproperty
   a_low: assert property (p_low) else $error("shutter not following low level");
   property p_rise;
      (trig_mode == stt_pkg::TRIG_RISE_TOGGLE) [*5] ##0 ($past(ttl_in, 3) && !$past(ttl_in, 4))
         |-> shutter_open != $past(shutter_open);
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge did not toggle");
   property p_fall;
      (trig_mode == stt_pkg::TRIG_FALL_TOGGLE) [*5] ##0 (!$past(ttl_in, 3) && $past(ttl_in, 4))
         |-> shutter_open != $past(shutter_open);
   endproperty
   a_fall: assert property (p_fall) else $error("falling edge did not toggle");
endmodule
bind stt_cmd stt_cmd_assertions chk (.*);

// file: stt_fifo.sv
`timescale 1ns/10ps
module stt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   // honest full and empty from the occupancy count
   assign in_ready = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data = mem_ff[rd_ptr_ff];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage has no reset; only the pointers and the count carry state
   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem_ff[wr_ptr_ff] <= in_data;
   end

   // pointers wrap at depth, so depth need not be a power of two
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + AW'(1);
         if (pop)
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + AW'(1);
         if (push && !pop)
            count_ff <= count_ff + (AW+1)'(1);
         else if (pop && !push)
            count_ff <= count_ff - (AW+1)'(1);
      end
   end

endmodule

// file: stt_host_model.sv
`timescale 1ns/10ps
module stt_host_model (
   input wire logic ref_clk,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic stall
);
   logic [7:0] got[$];
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
   // slow sink: every other cycle, so each reply byte must stand
   always @(negedge ref_clk)
      tx_ready <= !stall && !tx_ready;
   always @(posedge ref_clk)
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
   // byte held until the edge that takes it
   task send(input logic [7:0] b);
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_data = b;
      while (!rx_ready)
         @(negedge ref_clk);
      @(posedge ref_clk);
   endtask
   // data inverted on release so a stale byte never looks valid
   task idle();
      @(negedge ref_clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask
   task timer(input logic [3:0] sel, input logic [35:0] t);
      send(stt_pkg::SPECIAL_PREFIX);
      send({sel, t[35:32]});
      send(t[31:24]);
      send(t[23:16]);
      send(t[15:8]);
      send(t[7:0]);
      idle();
   endtask
endmodule

// file: stt_pkg.sv
package stt_pkg;

   // command stream framing
   localparam logic [7:0] SPECIAL_PREFIX = 8'hFA;
   localparam logic [3:0] SEL_DELAY = 4'h1;
   localparam logic [3:0] SEL_EXPOSURE = 4'h2;
   localparam logic [7:0] REPLY_TERMINATOR = 8'h0D;

   // single-byte command codes
   localparam logic [7:0] CMD_MOTOR_ON = 8'hCE;
   localparam logic [7:0] CMD_MOTOR_OFF = 8'hCF;
   localparam logic [7:0] CMD_GO_ONLINE = 8'hEE;
   localparam logic [7:0] CMD_STATUS_TAIL = 8'hCC;
   localparam logic [7:0] CMD_TRIG_DISABLE = 8'hA0;
   localparam logic [7:0] CMD_TRIG_HIGH = 8'hA1;
   localparam logic [7:0] CMD_TRIG_LOW = 8'hA2;
   localparam logic [7:0] CMD_TRIG_RISE = 8'hA3;
   localparam logic [7:0] CMD_TRIG_FALL = 8'hA4;

   // field limits of the shared time format
   localparam logic [3:0] HOURS_MAX = 4'h5;
   localparam logic [7:0] MINUTES_MAX = 8'h3B;
   localparam logic [7:0] SECONDS_MAX = 8'h3B;
   localparam logic [3:0] BCD_MAX = 4'h9;

   // repeat count handling
   localparam logic [15:0] REPEAT_LIMIT = 16'hFDE8;
   localparam logic [1:0] REPLY_LAST_IDX = 2'h2;

   // values after reset
   localparam logic RST_MOTOR_EN = 1'b0;
   localparam logic RST_ONLINE = 1'b0;
   localparam logic RST_SHUTTER_OPEN = 1'b0;

   localparam int FIFO_DEPTH = 4;
   localparam int BYTE_W = 8;

   typedef struct packed {
      logic [3:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
      logic [3:0] ms_hundreds;
      logic [3:0] ms_tens;
      logic [3:0] ms_ones;
      logic [3:0] ms_tenths;
   } stt_time_t;

   typedef enum logic [2:0] {
      TRIG_DISABLED,
      TRIG_LEVEL_HIGH,
      TRIG_LEVEL_LOW,
      TRIG_RISE_TOGGLE,
      TRIG_FALL_TOGGLE
   } stt_trig_mode_t;

endpackage

// file: test_shutter_timer_trigger_cmd.sv
`timescale 1ns/10ps
module test_shutter_timer_trigger_cmd;
   localparam logic [35:0] BAD [8] = '{36'h6_00_00_0000, 36'h5_01_00_0000, 36'h0_3C_00_0000, 36'h0_00_3C_0000,
      36'h0_00_00_A000, 36'h0_00_00_0A00, 36'h0_00_00_00A0, 36'h0_00_00_000A};
   logic ref_clk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready, ttl_in, online_key, local_req, stall;
   logic free_run_continuous, motor_power_en, online, delay_load, expo_load, shutter_open, cmd_rejected;
   logic [7:0] rx_data, tx_data;
   logic [15:0] repeat_count;
   stt_pkg::stt_time_t delay_time, expo_time;
   stt_pkg::stt_trig_mode_t trig_mode;
   int fail_count, checks, cycles, rej_n, dl_n, el_n, i;

   stt_cmd uut (.*);
   stt_host_model host (.*);

   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // counts discard pulses; a hang ends the run as a mismatch
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cmd_rejected === 1'b1)
         rej_n++;
      if (delay_load === 1'b1)
         dl_n++;
      if (expo_load === 1'b1)
         el_n++;
      if (cycles == 20000)
      begin
         fail_count++;
         end_sim();
      end
   end

   task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task end_sim();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task one(input logic [7:0] b);
      host.send(b);
      host.idle();
      repeat (8) @(negedge ref_clk);
   endtask
   // 5 cycles covers the two-flop path plus the update
   task pin(input logic v, input logic e);
      ttl_in = v;
      repeat (5) @(negedge ref_clk);
      chk("shutter", e, shutter_open);
   endtask

   initial
   begin
      {rst_n, ttl_in, online_key, local_req, stall} = 5'h00;
      repeat_count = 16'hFDE9;
      fail_count = 0;
      checks = 0;
      rej_n = 0;
      dl_n = 0;
      el_n = 0;
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      chk("rst", 36'h1, {motor_power_en, online, trig_mode, shutter_open, tx_valid, rx_ready});
      one(stt_pkg::CMD_MOTOR_ON);
      chk("motor", 0, motor_power_en);
      one(stt_pkg::CMD_GO_ONLINE);
      chk("online", 1, online);
      local_req = 1'b1;
      @(negedge ref_clk);
      local_req = 1'b0;
      @(negedge ref_clk);
      chk("online", 0, online);
      online_key = 1'b1;
      @(negedge ref_clk);
      online_key = 1'b0;
      @(negedge ref_clk);
      chk("online", 1, online);
      one(stt_pkg::CMD_MOTOR_ON);
      chk("motor", 1, motor_power_en);
      one(stt_pkg::CMD_MOTOR_OFF);
      chk("motor", 0, motor_power_en);
      $display("test mode and motor done");
      host.timer(stt_pkg::SEL_DELAY, 36'h4_3B_3B_9999);
      one(8'h00);
      chk("delay", 36'h4_3B_3B_9999, delay_time);
      host.timer(stt_pkg::SEL_EXPOSURE, 36'h5_00_00_0000);
      one(8'h00);
      chk("expo", 36'h5_00_00_0000, expo_time);
      // every range fault, alternating between the two timers
      for (i = 0; i < 8; i++)
      begin
         host.timer(i[0] ? stt_pkg::SEL_EXPOSURE : stt_pkg::SEL_DELAY, BAD[i]);
         one(8'h00);
         chk("rejects", i + 1, rej_n);
         chk("kept delay", 36'h4_3B_3B_9999, delay_time);
         chk("kept expo", 36'h5_00_00_0000, expo_time);
      end
      chk("loads", 36'h11, {dl_n[3:0], el_n[3:0]});
      host.send(stt_pkg::SPECIAL_PREFIX);
      one(8'h34);
      one(stt_pkg::CMD_MOTOR_ON);
      chk("bad select", {4'h9, 1'b1}, {rej_n[3:0], motor_power_en});
      $display("test timers done");
      stall = 1'b1;
      chk("continuous", 1, free_run_continuous);
      host.send(stt_pkg::CMD_STATUS_TAIL);
      for (i = 0; i < 4; i++)
         host.send(i[0] ? stt_pkg::CMD_MOTOR_OFF : stt_pkg::CMD_MOTOR_ON);
      host.idle();
      chk("full", 36'h1, {rx_ready, motor_power_en});
      stall = 1'b0;
      for (i = 0; i < 60 && host.got.size() < 3; i++)
         @(negedge ref_clk);
      repeat (8) @(negedge ref_clk);
      chk("reply", {12'h3, 24'hFDE90D}, {12'(host.got.size()), host.got[0], host.got[1], host.got[2]});
      chk("drained", 36'h2, {rx_ready, motor_power_en});
      repeat_count = 16'hFDE8;
      @(negedge ref_clk);
      chk("continuous", 0, free_run_continuous);
      $display("test reply done");
      one(stt_pkg::CMD_TRIG_HIGH);
      chk("mode", stt_pkg::TRIG_LEVEL_HIGH, trig_mode);
      pin(1'b1, 1'b1);
      pin(1'b0, 1'b0);
      one(stt_pkg::CMD_TRIG_LOW);
      pin(1'b1, 1'b0);
      pin(1'b0, 1'b1);
      one(stt_pkg::CMD_TRIG_DISABLE);
      pin(1'b1, 1'b1);
      pin(1'b0, 1'b1);
      one(stt_pkg::CMD_TRIG_RISE);
      pin(1'b1, 1'b0);
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b1);
      one(stt_pkg::CMD_TRIG_FALL);
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b0);
      pin(1'b0, 1'b1);
      host.send(stt_pkg::CMD_TRIG_HIGH);
      one(stt_pkg::CMD_TRIG_LOW);
      chk("mode", stt_pkg::TRIG_LEVEL_LOW, trig_mode);
      pin(1'b1, 1'b0);
      $display("test triggers done");
      end_sim();
   end
endmodule
